// file: hw/clock_gate_bank2.sv
/*
 * clock gating control for the ethernet phy, ethernet mac and eight ports.
 * holds run, sleep and deep sleep gate words, picks the active one and
 * drives one clock enable and one gated clock per unit; checks peripheral
 * accesses against the enables and flags a bus fault for gated units.
 * assumes a single 100 MHz clock, synchronous active-low reset and a
 * power mode input from the same clock domain.
 */
// Function
// R1 - enabled unit clocked, disabled unit stopped
// R2 - access to gated unit gives bus fault
// R3 - all gate bits zero after reset
// R4 - separate run, sleep, deep sleep words
// R5 - low-power words apply only with auto gating
// R6 - run word governs when auto gating clear
// R7 - bit 30 enables ethernet phy clock
// R8 - bit 28 enables ethernet mac clock
// R9 - bits 7..0 enable ports h..a
// R10 - reserved bits read zero, ignore writes
// R11 - software enables units before using them
// R12 - sleep word at offset 0x118
// R13 - deep sleep word at offset 0x128
// R14 - run word at offset 0x108
`timescale 1ns/10ps
module clock_gate_bank2 (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // power mode from the power controller
  input wire logic [1:0] power_mode,
  // peripheral access check, one select bit per unit
  input wire logic periph_req,
  input wire logic [clock_gate_pkg::unit_count-1:0] periph_sel,
  output logic periph_ok,
  output logic bus_fault,
  // per-unit clock enables and gated clocks
  output logic [clock_gate_pkg::unit_count-1:0] unit_clk_en,
  output logic [clock_gate_pkg::unit_count-1:0] unit_clk
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  clock_gate_pkg::reg_req_s req;
  logic [31:0] run_clock_gate_group2;
  logic [31:0] sleep_clock_gate_group2;
  logic [31:0] deep_sleep_clock_gate_group2;
  logic [31:0] run_clock_configuration;
  logic [31:0] next_run_clock_configuration;
  logic auto_low_power_gating;
  logic wr_run;
  logic wr_sleep;
  logic wr_deep;
  logic [31:0] active_word;
  logic [clock_gate_pkg::unit_count-1:0] next_unit_clk_en;
  logic [31:0] next_reg_rdata;
  logic next_periph_ok;
  logic next_bus_fault;
  clock_gate_pkg::power_mode_e mode;
  logic wr_config;
  logic [clock_gate_pkg::port_count-1:0] port_word;
  logic [clock_gate_pkg::unit_count-1:0] sel_gated;
  logic [31:0] status_word;
  genvar g;

  // power mode codes on the pins; code 3 is spare and runs
  localparam logic [1:0] code_sleep = 2'h1;
  localparam logic [1:0] code_deep_sleep = 2'h2;

  // one packed request keeps the decode readable
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ****************************************************************
  // address decode
  // ****************************************************************
  // R14 run word decode
  assign wr_run = req.wr &&
    (req.addr == clock_gate_pkg::run_clock_gate_group2_off);
  // R12 sleep word decode
  assign wr_sleep = req.wr &&
    (req.addr == clock_gate_pkg::sleep_clock_gate_group2_off);
  // R13 deep sleep decode
  assign wr_deep = req.wr &&
    (req.addr == clock_gate_pkg::deep_sleep_clock_gate_group2_off);

  // auto gating bit lives in the run clock configuration word
  assign wr_config = req.wr &&
    (req.addr == clock_gate_pkg::run_clock_configuration_off);

  // ****************************************************************
  // gate words
  // ****************************************************************
  // R4 three separate words
  gate_word u_run (
    .clk(clk),
    .nrst(nrst),
    .wr(wr_run),
    .wdata(req.wdata),
    .value(run_clock_gate_group2)
  );

  // low-power words only matter while auto gating is set
  gate_word u_sleep (
    .clk(clk),
    .nrst(nrst),
    .wr(wr_sleep),
    .wdata(req.wdata),
    .value(sleep_clock_gate_group2)
  );

  gate_word u_deep (
    .clk(clk),
    .nrst(nrst),
    .wr(wr_deep),
    .wdata(req.wdata),
    .value(deep_sleep_clock_gate_group2)
  );

  // ****************************************************************
  // run clock configuration (only the auto gating bit lives here)
  // ****************************************************************
  always_comb begin
    next_run_clock_configuration = run_clock_configuration;
    if (wr_config) begin
      // bits other than auto gating read back as zero
      next_run_clock_configuration = '0;
      next_run_clock_configuration[
        clock_gate_pkg::auto_low_power_gating_bit] =
        req.wdata[clock_gate_pkg::auto_low_power_gating_bit];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_clock_configuration <= clock_gate_pkg::config_reset;
    end else begin
      run_clock_configuration <= next_run_clock_configuration;
    end
  end

  assign auto_low_power_gating =
    run_clock_configuration[clock_gate_pkg::auto_low_power_gating_bit];

  // ****************************************************************
  // active word selection
  // ****************************************************************
  // unknown mode codes fall back to run so no unit is starved
  always_comb begin
    case (power_mode)
      code_sleep: mode = clock_gate_pkg::mode_sleep;
      code_deep_sleep: mode = clock_gate_pkg::mode_deep_sleep;
      default: mode = clock_gate_pkg::mode_run;
    endcase
  end

  always_comb begin
    active_word = run_clock_gate_group2;
    case (mode)
      clock_gate_pkg::mode_sleep: begin
        // R5 sleep word needs auto gating
        // R6 else run word stays
        if (auto_low_power_gating) begin
          active_word = sleep_clock_gate_group2;
        end
      end
      clock_gate_pkg::mode_deep_sleep: begin
        // R5 deep word needs auto gating
        // R6 else run word stays
        if (auto_low_power_gating) begin
          active_word = deep_sleep_clock_gate_group2;
        end
      end
      default: begin
        active_word = run_clock_gate_group2;
      end
    endcase
  end

  // ****************************************************************
  // per-unit enables
  // ****************************************************************
  // port n follows word bit n; one loop keeps the eight ports uniform
  generate
    for (g = 0; g < clock_gate_pkg::port_count; g++) begin : gen_port
      // R9 one bit per port
      assign port_word[g] =
        active_word[clock_gate_pkg::port_gate_lsb + g];
    end
  endgenerate

  always_comb begin
    next_unit_clk_en = '0;
    // R9 ports h..a
    next_unit_clk_en[clock_gate_pkg::port_count-1:0] = port_word;
    // R8 mac enable
    next_unit_clk_en[clock_gate_pkg::mac_unit] =
      active_word[clock_gate_pkg::eth_mac_gate_bit];
    // R7 phy enable
    next_unit_clk_en[clock_gate_pkg::phy_unit] =
      active_word[clock_gate_pkg::eth_phy_gate_bit];
  end

  // registered so every gate sees a settled enable for a full cycle
  always_ff @(posedge clk) begin
    // R3 all units off
    if (!nrst) begin
      unit_clk_en <= '0;
    end else begin
      unit_clk_en <= next_unit_clk_en;
    end
  end

  generate
    for (g = 0; g < clock_gate_pkg::unit_count; g++) begin : gen_gate
      // R1 per-unit clock gate
      unit_gate u_gate (
        .clk(clk),
        .en(unit_clk_en[g]),
        .gclk(unit_clk[g])
      );
    end
  endgenerate

  // ****************************************************************
  // peripheral access check
  // ****************************************************************
  // a selected unit whose enable is low marks the access as gated
  generate
    for (g = 0; g < clock_gate_pkg::unit_count; g++) begin : gen_check
      assign sel_gated[g] = periph_sel[g] & ~unit_clk_en[g];
    end
  endgenerate

  // software must enable units first; a stray access is faulted, not hung
  always_comb begin
    next_periph_ok = 1'b0;
    next_bus_fault = 1'b0;
    if (periph_req) begin
      // R2 gated unit faults
      // R11 software enables first
      if (sel_gated != '0 || periph_sel == '0) begin
        next_bus_fault = 1'b1;
      end else begin
        next_periph_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      periph_ok <= 1'b0;
      bus_fault <= 1'b0;
    end else begin
      periph_ok <= next_periph_ok;
      bus_fault <= next_bus_fault;
    end
  end

  // ****************************************************************
  // register read back
  // ****************************************************************
  // status view of the live enables, zero above the unit bits
  assign status_word = 32'(unit_clk_en);

  always_comb begin
    next_reg_rdata = '0;
    if (req.rd) begin
      case (req.addr)
        clock_gate_pkg::run_clock_gate_group2_off: begin
          next_reg_rdata = run_clock_gate_group2;
        end
        clock_gate_pkg::sleep_clock_gate_group2_off: begin
          next_reg_rdata = sleep_clock_gate_group2;
        end
        clock_gate_pkg::deep_sleep_clock_gate_group2_off: begin
          next_reg_rdata = deep_sleep_clock_gate_group2;
        end
        clock_gate_pkg::run_clock_configuration_off: begin
          next_reg_rdata = run_clock_configuration;
        end
        clock_gate_pkg::power_mode_off: begin
          next_reg_rdata = status_word;
        end
        default: begin
          next_reg_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      // zero outside read cycles so stale words never linger
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule : clock_gate_bank2

// file: hw/clock_gate_pkg.sv
/*
 * shared constants and types for the second clock gating bank.
 * assumes a 32-bit register port with byte offsets from the control base.
 */
package clock_gate_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] run_clock_gate_group2_off = 12'h108;
  localparam logic [11:0] sleep_clock_gate_group2_off = 12'h118;
  localparam logic [11:0] deep_sleep_clock_gate_group2_off = 12'h128;
  localparam logic [11:0] run_clock_configuration_off = 12'h060;
  localparam logic [11:0] power_mode_off = 12'h140;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int eth_phy_gate_bit = 30;
  localparam int eth_mac_gate_bit = 28;
  localparam int port_gate_lsb = 0;
  localparam int port_count = 8;
  localparam int auto_low_power_gating_bit = 27;
  localparam logic [31:0] gate_writable_mask = 32'h500000ff;
  localparam logic [31:0] gate_reset = 32'h00000000;
  localparam logic [31:0] config_reset = 32'h00000000;

  // number of gated units: phy, mac, eight ports
  localparam int unit_count = 10;
  localparam int phy_unit = 9;
  localparam int mac_unit = 8;

  typedef enum logic [1:0] {
    mode_run,
    mode_sleep,
    mode_deep_sleep
  } power_mode_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage : clock_gate_pkg

// file: hw/gate_word.sv
/*
 * one gate-enable word with reserved bits forced to zero.
 * assumes writes come from logic on the same clock.
 */
`timescale 1ns/10ps
module gate_word (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write side
  input wire logic wr,
  input wire logic [31:0] wdata,
  // stored word
  output logic [31:0] value
);

  logic [31:0] next_value;

  // ****************************************************************
  // storage
  // ****************************************************************
  always_comb begin
    next_value = value;
    // R10 reserved stay zero
    if (wr) begin
      next_value = wdata & clock_gate_pkg::gate_writable_mask;
    end
  end

  always_ff @(posedge clk) begin
    // R3 reset all gated
    if (!nrst) begin
      value <= clock_gate_pkg::gate_reset;
    end else begin
      value <= next_value;
    end
  end

endmodule : gate_word

// file: hw/unit_gate.sv
/*
 * glitch-free clock gate for one unit: enable latched while clock is low.
 * assumes the enable is produced on the rising edge of the same clock.
 */
`timescale 1ns/10ps
module unit_gate (
  // clock
  input wire logic clk,
  // enable
  input wire logic en,
  // gated clock
  output logic gclk
);

  logic en_lat;

  // ****************************************************************
  // latch based gate
  // ****************************************************************
  // a plain and gate would chop pulses when en moves mid-high phase
  always_latch begin
    if (!clk) begin
      en_lat <= en;
    end
  end

  // R1 clock only when enabled
  assign gclk = clk & en_lat;

endmodule : unit_gate

// file: verif/core_access.sv
/* core-side model that issues one-cycle peripheral accesses.
   assumes go and unit are driven by the bench after a rising edge. */
`timescale 1ns/10ps
module core_access (
  // clock
  input wire logic clk,
  // bench command; a unit above 9 gives an empty select
  input wire logic go,
  input wire logic [3:0] unit,
  // access request toward the gating bank
  output logic periph_req,
  output logic [clock_gate_pkg::unit_count-1:0] periph_sel
);
  initial begin
    periph_req = 1'b0;
    periph_sel = '0;
  end
  always @(posedge clk) begin
    periph_req <= go;
    // released select flips so a stale target cannot pass for a real one
    periph_sel <= go ? 10'h1 << unit : ~periph_sel;
  end
endmodule : core_access

// file: verif/gate_checker.sv
/* port assertions for clock_gate_bank2.
   assumes it is bound onto that module, one clock domain. */
`timescale 1ns/10ps
module gate_checker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // mode, access check, enables
  input wire logic [1:0] power_mode,
  input wire logic periph_req,
  input wire logic [clock_gate_pkg::unit_count-1:0] periph_sel,
  input wire logic periph_ok,
  input wire logic bus_fault,
  input wire logic [clock_gate_pkg::unit_count-1:0] unit_clk_en,
  input wire logic [clock_gate_pkg::unit_count-1:0] unit_clk
);
  logic [9:0] gated;
  logic [9:0] wmap;
  logic run_now;
  logic word_rd;
  assign gated = periph_sel & ~unit_clk_en;
  assign wmap = {reg_wdata[30], reg_wdata[28], reg_wdata[7:0]};
  assign run_now = power_mode != 2'h1 && power_mode != 2'h2;
  assign word_rd = reg_rd && reg_addr[3:0] == 4'h8 && reg_addr[11:8] == 4'h1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ****************************************************************
  // properties
  // ****************************************************************
  a_fault_gated:
    assert property (periph_req && (gated != 0 || periph_sel == 0)
      |=> bus_fault && !periph_ok) else $error("gated access not faulted");
  a_ok_open:
    assert property (periph_req && periph_sel != 0 && gated == 0
      |=> periph_ok && !bus_fault) else $error("open access refused");
  a_quiet_idle:
    assert property (!periph_req |=> !periph_ok && !bus_fault)
      else $error("answer without request");
  a_reset_zero:
    assert property ($rose(nrst) |-> unit_clk_en == 0 && reg_rdata == 0)
      else $error("state not clear after reset");
  a_run_write:
    assert property (reg_wr && run_now
      && reg_addr == clock_gate_pkg::run_clock_gate_group2_off
      ##1 !reg_wr && run_now |=> unit_clk_en == $past(wmap, 2))
      else $error("run word not driving enables");
  a_read_idle:
    assert property (!reg_rd |=> reg_rdata == 0)
      else $error("read data outside read cycle");
  a_read_reserved:
    assert property (word_rd
      |=> (reg_rdata & ~clock_gate_pkg::gate_writable_mask) == 0)
      else $error("reserved bits read nonzero");
  a_status_copy:
    assert property (reg_rd && reg_addr == clock_gate_pkg::power_mode_off
      |=> reg_rdata == {22'h0, $past(unit_clk_en)})
      else $error("status differs from enables");
endmodule : gate_checker

bind clock_gate_bank2 gate_checker chk (.clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .power_mode, .periph_req, .periph_sel,
  .periph_ok, .bus_fault, .unit_clk_en, .unit_clk);

// file: verif/tb_top.sv
/* self-checking bench for clock_gate_bank2.
   assumes core_access as the core and gate_checker bound to the design. */
`timescale 1ns/10ps
module tb_top;
  localparam logic [11:0] offs [3] = '{
    clock_gate_pkg::run_clock_gate_group2_off,
    clock_gate_pkg::sleep_clock_gate_group2_off,
    clock_gate_pkg::deep_sleep_clock_gate_group2_off};
  logic clk, nrst, reg_wr, reg_rd, go, bus_fault, periph_ok, req, auto;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rnd, cfg;
  logic [31:0] w [3];
  logic [1:0] power_mode;
  logic [3:0] unit;
  logic [9:0] sel, en, gclk, e;
  int fails, cmp_count, cyc;

  clock_gate_bank2 DUT (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .power_mode, .periph_req(req), .periph_sel(sel),
    .periph_ok, .bus_fault, .unit_clk_en(en), .unit_clk(gclk));
  core_access core (.clk, .go, .unit, .periph_req(req), .periph_sel(sel));

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // low-power words only count with auto gating on
  function automatic logic [9:0] act();
    logic [31:0] v;
    v = w[0];
    if (auto && power_mode == 2'h1) v = w[1];
    if (auto && power_mode == 2'h2) v = w[2];
    return {v[30], v[28], v[7:0]};
  endfunction : act

  task automatic check(input string n, input logic [31:0] x, s);
    cmp_count++;
    if (s !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("read data", x, reg_rdata);
    @(posedge clk);
  endtask : rd

  task automatic acc(input logic [3:0] u);
    logic f;
    f = u > 4'h9 || !e[u];
    go <= 1'b1;
    unit <= u;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    check("bus fault", 32'(f), 32'(bus_fault));
    check("access ok", 32'(!f), 32'(periph_ok));
    @(posedge clk);
  endtask : acc

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    clk = 0;
    nrst = 0;
    {reg_wr, reg_rd, go, auto, unit, power_mode} = '0;
    reg_addr = 0;
    reg_wdata = 0;
    e = 0;
    w = '{default: 0};
    rnd = 32'h19;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (offs[i]) rd(offs[i], 32'h0);
    for (int u = 0; u < 16; u += 3) acc(4'(u));
    repeat (16) begin
      foreach (offs[i]) begin
        rnd = lfsr(rnd);
        w[i] = rnd & clock_gate_pkg::gate_writable_mask;
        wr(offs[i], rnd);
        rd(offs[i], w[i]);
      end
      rnd = lfsr(rnd);
      auto = rnd[27];
      wr(clock_gate_pkg::run_clock_configuration_off, rnd);
      cfg = 32'(auto) << clock_gate_pkg::auto_low_power_gating_bit;
      rd(clock_gate_pkg::run_clock_configuration_off, cfg);
      power_mode <= rnd[9:8];
      repeat (2) @(posedge clk);
      #2;
      e = act();
      check("enables", 32'(e), 32'(en));
      check("gated clocks", 32'(e), 32'(gclk));
      @(posedge clk);
      wr(clock_gate_pkg::power_mode_off, rnd);
      rd(clock_gate_pkg::power_mode_off, 32'(e));
      acc(rnd[15:12]);
    end
    // mid-run reset must clear every word and the auto gating bit
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    auto = 1'b0;
    w = '{default: 0};
    e = act();
    foreach (offs[i]) rd(offs[i], 32'h0);
    rd(clock_gate_pkg::run_clock_configuration_off, 32'h0);
    rd(clock_gate_pkg::power_mode_off, 32'h0);
    acc(4'h9);
    report_and_stop();
  end
endmodule : tb_top
